// ==== pimc_map.vh ====
`ifndef PIMC_MAP_VH
`define PIMC_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PIMC_A_CTRL0     8'h00
`define PIMC_A_EXTCTL    8'h04
`define PIMC_A_VTBASE    8'h08
`define PIMC_A_RESETPC   8'h0C
`define PIMC_A_QLEAF     8'h10
`define PIMC_A_QDATA     8'h14
`define PIMC_A_QCOUNT    8'h18
`define PIMC_A_MREGIDX   8'h1C
`define PIMC_A_MREGDAT   8'h20
`define PIMC_A_ACCADR    8'h24
`define PIMC_A_ACCTYPE   8'h28
`define PIMC_A_NMIDONE   8'h2C
`define PIMC_A_SIMDCHK   8'h30
`define PIMC_A_IRQSTAT   8'h34
`define PIMC_A_IRQCLR    8'h38
`define PIMC_A_IRQEN     8'h3C
// ----------------------------------------
// Fields and values
// ----------------------------------------
`define PIMC_PE_BIT      0
`define PIMC_OSSAVE_BIT  9
`define PIMC_OSFAULT_BIT 10
`define PIMC_F_EXT1      25
`define PIMC_F_EXT2      26
`define PIMC_F_EXT3      0
`define PIMC_F_SAVE      24
`define PIMC_F_FLUSH     19
`define PIMC_RESET_PC    32'h0FFF_FFF0
`define PIMC_VT_RST      32'h0000_0000
`define PIMC_LEAF_FEAT   32'h0000_0001
`define PIMC_REAL_MASK   32'h000F_FFFF
`define PIMC_TYPE_UC     3'h0
`define PIMC_NRANGE      4
`define PIMC_IDX_W       3
`define PIMC_RNG_VALID   11
`define PIMC_CHK_FAULT   0
`define PIMC_CHK_INSTR   1
// Interrupt status bits
`define PIMC_I_NMI       0
`define PIMC_I_PROT      1
`define PIMC_I_SIMDF     2
`define PIMC_I_SIMDUD    3
`define PIMC_NIRQ        4
`endif

// ==== pimc_range.v ====
`include "pimc_map.vh"
// One memory range entry: base, mask, type
module pimc_range (
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  input  wire        wr_base_i,
  input  wire        wr_mask_i,
  input  wire [31:0] wdata_i,
  input  wire [31:0] addr_i,
  output wire        hit_o,
  output wire [2:0]  type_o,
  output wire [31:0] base_o,
  output wire [31:0] mask_o
);
  reg [31:0] base_q;
  reg [31:0] mask_q;

  // ----------------------------------------
  // Range storage
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      base_q <= 32'h0000_0000;
      mask_q <= 32'h0000_0000;
    end else begin
      if (wr_base_i) base_q <= wdata_i;
      if (wr_mask_i) mask_q <= wdata_i;
    end
  end

  // Base bits [2:0] hold the type; mask bit 11 is valid
  assign type_o = base_q[2:0];
  assign hit_o  = mask_q[`PIMC_RNG_VALID] && ((addr_i & {mask_q[31:12], 12'h000}) ==
                  (base_q & {mask_q[31:12], 12'h000}));
  assign base_o = base_q;
  assign mask_o = mask_q;
endmodule // pimc_range

// ==== pimc_core.v ====
// The address-and-strobe port and the register addresses are this design's own decisions.
`include "pimc_map.vh"
// Initialisation and mode control of the core
module pimc_core (
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire        nmi_i,
  output wire        prot_mode_o,
  output reg  [31:0] fetch_addr_o,
  output wire [31:0] vt_base_o,
  output wire        simd_exec_en_o,
  output wire        simd_fault_en_o,
  output wire        nmi_take_o,
  output wire        irq_o
);
  // ----------------------------------------
  // Control state
  // ----------------------------------------
  reg  [31:0] ctrl0_q;
  reg  [31:0] ext_q;
  reg  [31:0] vt_q;
  reg  [31:0] leaf_q;
  reg  [31:0] qdata_q;
  reg  [31:0] qcount_q;
  reg  [2:0]  midx_q;
  reg  [31:0] acc_q;
  reg         nmi_busy_q;
  reg         nmi_s1_q;
  reg         nmi_s2_q;
  reg         nmi_s3_q;
  reg  [3:0]  stat_q;
  reg  [3:0]  en_q;
  reg  [3:0]  ev;
  reg  [31:0] mdat;
  reg  [2:0]  acc_type;
  reg         hit_any;
  wire [31:0] acc_eff;
  wire [31:0] feat_data;
  wire [31:0] feat_count;
  wire        nmi_edge;
  wire        prot_set;
  wire        wr_ctrl0;
  wire        wr_extctl;
  wire        wr_vtbase;
  wire        wr_resetpc;
  wire        wr_qleaf;
  wire        wr_midx;
  wire        wr_mdat;
  wire        wr_accadr;
  wire        wr_nmidone;
  wire        wr_simdchk;
  wire        wr_irqclr;
  wire        wr_irqen;
  wire [2*`PIMC_NRANGE-1:0] wr_rng;
  wire [`PIMC_NRANGE-1:0]   hit;
  wire [3*`PIMC_NRANGE-1:0] rtype;
  wire [32*`PIMC_NRANGE-1:0] rbase;
  wire [32*`PIMC_NRANGE-1:0] rmask;
  integer i;
  integer j;

  // ----------------------------------------
  // Address decode of the register port
  // ----------------------------------------
  assign wr_ctrl0   = wr_i && (addr_i == `PIMC_A_CTRL0);
  assign wr_extctl  = wr_i && (addr_i == `PIMC_A_EXTCTL);
  assign wr_vtbase  = wr_i && (addr_i == `PIMC_A_VTBASE);
  assign wr_resetpc = wr_i && (addr_i == `PIMC_A_RESETPC);
  assign wr_qleaf   = wr_i && (addr_i == `PIMC_A_QLEAF);
  assign wr_midx    = wr_i && (addr_i == `PIMC_A_MREGIDX);
  assign wr_mdat    = wr_i && (addr_i == `PIMC_A_MREGDAT);
  assign wr_accadr  = wr_i && (addr_i == `PIMC_A_ACCADR);
  assign wr_nmidone = wr_i && (addr_i == `PIMC_A_NMIDONE);
  assign wr_simdchk = wr_i && (addr_i == `PIMC_A_SIMDCHK);
  assign wr_irqclr  = wr_i && (addr_i == `PIMC_A_IRQCLR);
  assign wr_irqen   = wr_i && (addr_i == `PIMC_A_IRQEN);

  // ----------------------------------------
  // Mode and status outputs
  // ----------------------------------------
  assign prot_mode_o     = ctrl0_q[`PIMC_PE_BIT];
  assign vt_base_o       = vt_q;
  assign simd_exec_en_o  = ext_q[`PIMC_OSSAVE_BIT];
  assign simd_fault_en_o = ext_q[`PIMC_OSFAULT_BIT];
  assign prot_set        = wr_ctrl0 && wdata_i[`PIMC_PE_BIT] && !ctrl0_q[`PIMC_PE_BIT];
  // Real mode truncates the access address to its low 20 bits
  assign acc_eff = prot_mode_o ? acc_q : (acc_q & `PIMC_REAL_MASK);

  // Feature words returned for the feature leaf
  assign feat_data  = (32'h0000_0001 << `PIMC_F_EXT1) |
                      (32'h0000_0001 << `PIMC_F_EXT2) |
                      (32'h0000_0001 << `PIMC_F_SAVE) |
                      (32'h0000_0001 << `PIMC_F_FLUSH);
  assign feat_count = 32'h0000_0001 << `PIMC_F_EXT3;

  // ----------------------------------------
  // Pin synchroniser for the request pin
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_s3_q <= 1'b0;
    end else begin
      nmi_s1_q <= nmi_i;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
    end
  end
  // Rising edge of the synchronised pin; third flop holds the old level
  assign nmi_edge   = nmi_s2_q && !nmi_s3_q;
  // Taken with no mask, unless one is in service; any gating is board side
  assign nmi_take_o = nmi_edge && !nmi_busy_q;

  // ----------------------------------------
  // Range entries
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PIMC_NRANGE; g = g + 1) begin : g_rng
      pimc_range u_rng (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .wr_base_i (wr_rng[2*g]),
        .wr_mask_i (wr_rng[2*g+1]),
        .wdata_i   (wdata_i),
        .addr_i    (acc_eff),
        .hit_o     (hit[g]),
        .type_o    (rtype[3*g+2:3*g]),
        .base_o    (rbase[32*g+31:32*g]),
        .mask_o    (rmask[32*g+31:32*g])
      );
      assign wr_rng[2*g]   = wr_i && (addr_i == `PIMC_A_MREGDAT) &&
                             (midx_q == (2*g));
      assign wr_rng[2*g+1] = wr_i && (addr_i == `PIMC_A_MREGDAT) &&
                             (midx_q == (2*g+1));
    end
  endgenerate

  // Type of the current access; lowest hit wins, none means uncached
  always @* begin
    acc_type = `PIMC_TYPE_UC;
    hit_any  = 1'b0;
    for (i = `PIMC_NRANGE - 1; i >= 0; i = i - 1) begin
      if (hit[i]) begin
        acc_type = rtype[3*i +: 3];
        hit_any  = 1'b1;
      end
    end
  end

  // Model register read mux
  always @* begin
    mdat = 32'h0000_0000;
    for (j = 0; j < `PIMC_NRANGE; j = j + 1) begin
      if (midx_q == 2*j) mdat = rbase[32*j +: 32];
      if (midx_q == 2*j + 1) mdat = rmask[32*j +: 32];
    end
  end

  // ----------------------------------------
  // Control words
  // ----------------------------------------
  // Protection enable clear after reset keeps real mode
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl0_q <= 32'h0000_0000;
      ext_q   <= 32'h0000_0000;
    end else begin
      if (wr_ctrl0) ctrl0_q <= wdata_i;
      if (wr_extctl) ext_q <= wdata_i;
    end
  end

  // Vector table base and fetch address
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vt_q         <= `PIMC_VT_RST;
      fetch_addr_o <= `PIMC_RESET_PC;
    end else begin
      if (wr_vtbase) vt_q <= wdata_i;
      if (wr_resetpc) fetch_addr_o <= wdata_i;
    end
  end

  // ----------------------------------------
  // Feature query
  // ----------------------------------------
  // Query runs on a leaf write; other leaves return zeros
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      leaf_q   <= 32'h0000_0000;
      qdata_q  <= 32'h0000_0000;
      qcount_q <= 32'h0000_0000;
    end else if (wr_qleaf) begin
      leaf_q <= wdata_i;
      if (wdata_i == `PIMC_LEAF_FEAT) begin
        qdata_q  <= feat_data;
        qcount_q <= feat_count;
      end else begin
        qdata_q  <= 32'h0000_0000;
        qcount_q <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Model register index, access address, service flag
  // ----------------------------------------
  // Index selects a range word; access address feeds the lookup
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      midx_q <= 3'h0;
      acc_q  <= 32'h0000_0000;
    end else begin
      if (wr_midx) midx_q <= wdata_i[`PIMC_IDX_W-1:0];
      if (wr_accadr) acc_q <= wdata_i;
    end
  end

  // In service from take until handler signals done; take wins
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nmi_busy_q <= 1'b0;
    end else if (nmi_take_o) begin
      nmi_busy_q <= 1'b1;
    end else if (wr_nmidone) begin
      nmi_busy_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  // Event pulses for the sticky status
  always @* begin
    ev = 4'h0;
    ev[`PIMC_I_NMI]  = nmi_take_o;
    ev[`PIMC_I_PROT] = prot_set;
    // SIMD check: one bit reports a fault, the other an instruction
    ev[`PIMC_I_SIMDF]  = wr_simdchk && wdata_i[`PIMC_CHK_FAULT] &&
                         ext_q[`PIMC_OSFAULT_BIT];
    ev[`PIMC_I_SIMDUD] = wr_simdchk && wdata_i[`PIMC_CHK_INSTR] &&
                         !ext_q[`PIMC_OSSAVE_BIT];
  end

  // Sticky status; set wins over clear
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_q <= 4'h0;
    end else if (wr_irqclr) begin
      stat_q <= (stat_q & ~wdata_i[3:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  // Enable mask for the level output
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_q <= 4'h0;
    end else if (wr_irqen) begin
      en_q <= wdata_i[3:0];
    end
  end

  // Level output while an enabled status bit is set
  assign irq_o = |(stat_q & en_q);

  // ----------------------------------------
  // Read port, data one cycle after strobe
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        `PIMC_A_CTRL0:   rdata_o <= ctrl0_q;
        `PIMC_A_EXTCTL:  rdata_o <= ext_q;
        `PIMC_A_VTBASE:  rdata_o <= vt_q;
        `PIMC_A_RESETPC: rdata_o <= fetch_addr_o;
        `PIMC_A_QLEAF:   rdata_o <= leaf_q;
        `PIMC_A_QDATA:   rdata_o <= qdata_q;
        `PIMC_A_QCOUNT:  rdata_o <= qcount_q;
        `PIMC_A_MREGIDX: rdata_o <= {29'h0, midx_q};
        `PIMC_A_MREGDAT: rdata_o <= mdat;
        `PIMC_A_ACCADR:  rdata_o <= acc_eff;
        `PIMC_A_ACCTYPE: rdata_o <= {27'h0, hit_any, nmi_busy_q, acc_type};
        `PIMC_A_IRQSTAT: rdata_o <= {28'h000_0000, stat_q};
        `PIMC_A_IRQEN:   rdata_o <= {28'h000_0000, en_q};
        default:         rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule // pimc_core

// ==== pimc_core_asserts.sv ====
module pimc_core_asserts (
  input logic        clk_sys_i,
  input logic        nrst_i,
  input logic [7:0]  addr_i,
  input logic [31:0] wdata_i,
  input logic        wr_i,
  input logic        rd_i,
  input logic [31:0] rdata_o,
  input logic        nmi_i,
  input logic        prot_mode_o,
  input logic [31:0] fetch_addr_o,
  input logic [31:0] vt_base_o,
  input logic        simd_exec_en_o,
  input logic        simd_fault_en_o,
  input logic        nmi_take_o,
  input logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // Leaf one query then data word read
  sequence s_leaf1; wr_i && addr_i == 8'h10 && wdata_i == 32'h0000_0001; endsequence
  sequence s_rd_feat; rd_i && addr_i == 8'h14; endsequence
  property p_rst; $rose(nrst_i) |-> !prot_mode_o && fetch_addr_o == 32'h0FFF_FFF0 && vt_base_o == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_prot; wr_i && addr_i == 8'h00 && wdata_i[0] |=> prot_mode_o; endproperty
  a_prot: assert property (p_prot) else $error("protected mode not entered");
  property p_vt; wr_i && addr_i == 8'h08 |=> vt_base_o == $past(wdata_i); endproperty
  a_vt: assert property (p_vt) else $error("table base not loaded");
  property p_vt_rd; rd_i && addr_i == 8'h08 |=> rdata_o == vt_base_o; endproperty
  a_vt_rd: assert property (p_vt_rd) else $error("table base read wrong");
  property p_save; wr_i && addr_i == 8'h04 |=> simd_exec_en_o == $past(wdata_i[9]); endproperty
  a_save: assert property (p_save) else $error("save flag wrong");
  property p_fault; wr_i && addr_i == 8'h04 |=> simd_fault_en_o == $past(wdata_i[10]); endproperty
  a_fault: assert property (p_fault) else $error("fault flag wrong");
  property p_feat; s_leaf1 ##[1:2] s_rd_feat |=> rdata_o == 32'h0708_0000; endproperty
  a_feat: assert property (p_feat) else $error("feature flags wrong");
  property p_nmi; nmi_take_o |-> $past(nmi_i, 2) && !$past(nmi_i, 3); endproperty
  a_nmi: assert property (p_nmi) else $error("take without request");
  property p_nmi_one; nmi_take_o |=> !nmi_take_o; endproperty
  a_nmi_one: assert property (p_nmi_one) else $error("take longer than a pulse");
endmodule // pimc_core_asserts

bind pimc_core pimc_core_asserts u_pimc_core_asserts (.*);

// ==== pimc_board.sv ====
module pimc_board (
  input  logic clk_sys_i,
  input  logic nrst_i,
  input  logic flag_wr_i,
  input  logic req_i,
  output logic nmi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flag_q;
  // Port flag, cleared by reset, set by software
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) flag_q <= 1'b0;
    else if (flag_wr_i) flag_q <= 1'b1;
  end
  // Request pin gated by the flag
  assign nmi_o = req_i & flag_q;
endmodule // pimc_board

// ==== pimc_core_test.sv ====
module pimc_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        req = 1'b0;
  logic        flag_wr = 1'b0;
  logic        nmi;
  logic [31:0] rdata_o;
  logic [31:0] vt_base_o;
  logic        prot_mode_o;
  logic        simd_exec_en_o;
  logic        simd_fault_en_o;
  logic        nmi_take_o;
  logic        irq_o;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n_take = 0;
  int          cyc = 0;

  pimc_board u_pimc_board (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .flag_wr_i(flag_wr), .req_i(req), .nmi_o(nmi));
  pimc_core u_pimc_core (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .nmi_i(nmi), .prot_mode_o(prot_mode_o), .fetch_addr_o(), .vt_base_o(vt_base_o),
    .simd_exec_en_o(simd_exec_en_o), .simd_fault_en_o(simd_fault_en_o), .nmi_take_o(nmi_take_o), .irq_o(irq_o));

  // Clock
  always #50 clk_sys_i = ~clk_sys_i;

  // Take counter and hang limit
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (nmi_take_o === 1'b1) n_take <= n_take + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(negedge clk_sys_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    cmp($sformatf("reg %h", a), exp, rdata_o);
  endtask

  // Board request held four cycles, then settle
  task automatic pulse_nmi();
    @(posedge clk_sys_i);
    req <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    req <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'h0FFF_FFF0);
    rd(8'h08, 32'h0);
    rd(8'h28, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h10, 32'h0000_0001);
    rd(8'h14, 32'h0708_0000);
    rd(8'h18, 32'h0000_0001);
    wr(8'h10, 32'h0000_0002);
    rd(8'h14, 32'h0);
    wr(8'h08, 32'h0001_2340);
    rd(8'h08, 32'h0001_2340);
    cmp("vt base", 32'h0001_2340, vt_base_o);
    wr(8'h1C, 32'h0);
    wr(8'h20, 32'h0004_5006);
    wr(8'h1C, 32'h0000_0001);
    wr(8'h20, 32'hFFFF_F800);
    rd(8'h20, 32'hFFFF_F800);
    wr(8'h24, 32'h1234_5678);
    rd(8'h28, 32'h0000_0016);
    wr(8'h30, 32'h0000_0002);
    wr(8'h30, 32'h0);
    rd(8'h34, 32'h0000_0008);
    wr(8'h04, 32'h0000_0600);
    cmp("simd en", 32'h0000_0003, {30'h0, simd_fault_en_o, simd_exec_en_o});
    wr(8'h30, 32'h0000_0001);
    wr(8'h30, 32'h0);
    rd(8'h34, 32'h0000_000C);
    wr(8'h3C, 32'h0000_0004);
    cmp("irq", 32'h1, {31'h0, irq_o});
    wr(8'h38, 32'h0000_000F);
    cmp("irq", 32'h0, {31'h0, irq_o});
    pulse_nmi();
    cmp("takes", 32'h0, n_take);
    @(posedge clk_sys_i);
    flag_wr <= 1'b1;
    @(posedge clk_sys_i);
    flag_wr <= 1'b0;
    pulse_nmi();
    cmp("takes", 32'h1, n_take);
    rd(8'h28, 32'h0000_001E);
    pulse_nmi();
    cmp("takes", 32'h1, n_take);
    wr(8'h2C, 32'h0);
    pulse_nmi();
    cmp("takes", 32'h2, n_take);
    wr(8'h2C, 32'h0);
    rd(8'h34, 32'h0000_0001);
    wr(8'h00, 32'h0000_0001);
    cmp("prot", 32'h1, {31'h0, prot_mode_o});
    rd(8'h28, 32'h0);
    rd(8'h34, 32'h0000_0003);
    wr(8'h3C, 32'h0000_000F);
    cmp("irq", 32'h1, {31'h0, irq_o});
    // Warm reset mid-run restores the reset state and the board flag
    wr(8'h0C, 32'h0000_1000);
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd(8'h0C, 32'h0FFF_FFF0);
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    cmp("irq", 32'h0, {31'h0, irq_o});
    pulse_nmi();
    cmp("takes", 32'h2, n_take);
    print_verdict();
  end
endmodule // pimc_core_test
